// *** pkg/hfc_consts.vh ***
/*
 Constants for the host-side controller of a strobe-driven 9-bit FIFO:
 state codes and pin timing figures with their cycle counts.
 Assumes a single 40 MHz system clock; all waits round up to whole cycles.
*/
`ifndef HFC_CONSTS_VH
`define HFC_CONSTS_VH

// ==========================================================================
// Clock and conversion.
`define HFC_CLK_PS        25000
`define HFC_CYC(ns)       ((((ns) * 1000) + `HFC_CLK_PS - 1) / `HFC_CLK_PS)

// ==========================================================================
// Pin timing in ns, fastest documented grade.
`define HFC_T_RS_NS       30
`define HFC_T_RSS_NS      30
`define HFC_T_RSR_NS      10
`define HFC_T_FLAG_RS_NS  40
`define HFC_T_WPW_NS      30
`define HFC_T_DS_NS       18
`define HFC_T_WR_NS       10
`define HFC_T_RPW_NS      30
`define HFC_T_ACC_NS      30
`define HFC_T_RR_NS       10
`define HFC_T_FLAG_NS     30
`define HFC_T_RT_NS       30
`define HFC_T_RTR_NS      10
`define HFC_T_RTF_NS      40

// ==========================================================================
// Cycle counts derived from the times above.
`define HFC_MAX(a, b)     (((a) > (b)) ? (a) : (b))
`define HFC_RS_CYC   `HFC_CYC(`HFC_MAX(`HFC_T_RS_NS, `HFC_T_RSS_NS))
`define HFC_RSR_CYC  `HFC_CYC(`HFC_MAX(`HFC_T_RSR_NS, `HFC_T_FLAG_RS_NS))
`define HFC_WLO_CYC  `HFC_CYC(`HFC_MAX(`HFC_T_WPW_NS, `HFC_T_DS_NS))
`define HFC_WHI_CYC  `HFC_CYC(`HFC_MAX(`HFC_T_WR_NS, `HFC_T_FLAG_NS))
`define HFC_RLO_CYC  `HFC_CYC(`HFC_MAX(`HFC_T_RPW_NS, `HFC_T_ACC_NS))
`define HFC_RHI_CYC  `HFC_CYC(`HFC_MAX(`HFC_T_RR_NS, `HFC_T_FLAG_NS))
`define HFC_RT_CYC   `HFC_CYC(`HFC_T_RT_NS)
`define HFC_RTR_CYC  `HFC_CYC(`HFC_MAX(`HFC_T_RTR_NS, `HFC_T_RTF_NS))

// ==========================================================================
// Controller states.
`define HFC_S_RST         4'h0
`define HFC_S_RREC        4'h1
`define HFC_S_IDLE        4'h2
`define HFC_S_WLO         4'h3
`define HFC_S_WHI         4'h4
`define HFC_S_RLO         4'h5
`define HFC_S_RHI         4'h6
`define HFC_S_TLO         4'h7
`define HFC_S_THI         4'h8

`endif

// *** logic/hfc_skid.v ***
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module hfc_skid #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  // ========================================================================
  // Storage.
  reg [W-1:0] mem_reg [0:1];
  reg         wp_reg;
  reg         rp_reg;
  reg [1:0]   cnt_reg;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];

  always @(posedge clk) begin
    if (sys_rst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg          <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end

endmodule // hfc_skid

// *** logic/hfc_ctrl.v ***
/*
 Host controller that drives a strobe-operated 9-bit FIFO device through
 its pins: reset, write strobe, read strobe, retransmit and expansion.
 Assumes device flags and read data are synchronous to clk and that the
 device is wired alone (single-device mode).
*/
`timescale 1ns/1ps
`include "hfc_consts.vh"

module hfc_ctrl #(
  parameter DW    = 9,
  parameter DEPTH = 256,
  parameter CW    = 11
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire          dev_reset_req,
  output wire          dev_reset_ready,
  input  wire          wr_valid,
  output wire          wr_ready,
  input  wire [DW-1:0] wr_data,
  output wire          rd_valid,
  input  wire          rd_ready,
  output wire [DW-1:0] rd_data,
  input  wire          rewind_req,
  output wire          rewind_ready,
  output wire          rewind_ok,
  output wire          busy,
  output reg           dev_full,
  output reg           dev_empty,
  output reg           dev_half,
  output reg           reset_n_in,
  output reg           w_n,
  output reg           r_n,
  output reg           first_or_rewind_in,
  output wire          chain_in_n,
  output reg  [DW-1:0] wr_word_in,
  input  wire [DW-1:0] rd_word_out,
  input  wire          full_ind_n,
  input  wire          empty_ind_n,
  input  wire          half_full_ind_n
);

  // ========================================================================
  // Timing counts.
  // Every wait fits the four-bit counter; the slice makes the cut explicit.
  function [3:0] cyc4;
    input integer c;
    begin
      cyc4 = c[3:0];
    end
  endfunction

  localparam [3:0] RS_CYC  = cyc4(`HFC_RS_CYC);
  localparam [3:0] RSR_CYC = cyc4(`HFC_RSR_CYC);
  localparam [3:0] WLO_CYC = cyc4(`HFC_WLO_CYC);
  localparam [3:0] WHI_CYC = cyc4(`HFC_WHI_CYC);
  localparam [3:0] RLO_CYC = cyc4(`HFC_RLO_CYC);
  localparam [3:0] RHI_CYC = cyc4(`HFC_RHI_CYC);
  localparam [3:0] RT_CYC  = cyc4(`HFC_RT_CYC);
  localparam [3:0] RTR_CYC = cyc4(`HFC_RTR_CYC);
  localparam integer  DEPTH_I = DEPTH;
  localparam [CW-1:0] DEPTH_C = DEPTH_I[CW-1:0];

  // ========================================================================
  // State.
  reg  [3:0]    state_reg;
  reg  [3:0]    state_next;
  reg  [3:0]    cnt_reg;
  reg  [3:0]    cnt_next;
  reg  [CW-1:0] wcnt_reg;
  reg           last_rd_reg;
  wire          sk_in_ready;
  reg           sk_push;
  wire          idle = (state_reg == `HFC_S_IDLE);
  wire          last = (cnt_reg == 4'h1);

  // Single device only: chaining would disable retransmit and half-full.
  assign chain_in_n = 1'b0;

  // ========================================================================
  // Arbitration. Reads and writes alternate when both are possible so a
  // steady writer cannot starve the reader.
  wire can_rd = empty_ind_n && sk_in_ready;
  wire can_wr = wr_valid && full_ind_n;
  // Rewinding past a full lap would replay overwritten words.
  assign rewind_ok = (wcnt_reg < DEPTH_C);
  assign dev_reset_ready = idle;
  wire rst_go = idle && dev_reset_req;
  wire rt_go  = idle && !dev_reset_req && rewind_req && rewind_ok;
  wire rd_go  = idle && !dev_reset_req && !rt_go && can_rd &&
                (!can_wr || !last_rd_reg);
  wire wr_go  = idle && !dev_reset_req && !rt_go && can_wr &&
                !rd_go;
  assign wr_ready     = wr_go;
  assign rewind_ready = rt_go;
  assign busy         = !idle;

  // ========================================================================
  // Sequencer.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sk_push    = 1'b0;
    case (state_reg)
      `HFC_S_RST: begin
        if (last) begin
          state_next = `HFC_S_RREC;
          cnt_next   = RSR_CYC;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      `HFC_S_RREC: begin
        if (last)
          state_next = `HFC_S_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      `HFC_S_IDLE: begin
        if (rst_go) begin
          state_next = `HFC_S_RST;
          cnt_next   = RS_CYC;
        end else if (rt_go) begin
          state_next = `HFC_S_TLO;
          cnt_next   = RT_CYC;
        end else if (rd_go) begin
          state_next = `HFC_S_RLO;
          cnt_next   = RLO_CYC;
        end else if (wr_go) begin
          state_next = `HFC_S_WLO;
          cnt_next   = WLO_CYC;
        end
      end
      `HFC_S_WLO: begin
        if (last) begin
          state_next = `HFC_S_WHI;
          cnt_next   = WHI_CYC;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      `HFC_S_RLO: begin
        if (last) begin
          // Sample before the strobe rises; the bus floats after it.
          sk_push    = 1'b1;
          state_next = `HFC_S_RHI;
          cnt_next   = RHI_CYC;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      `HFC_S_TLO: begin
        if (last) begin
          state_next = `HFC_S_THI;
          cnt_next   = RTR_CYC;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      `HFC_S_WHI, `HFC_S_RHI, `HFC_S_THI: begin
        // Flags settle here before the next decision is taken.
        if (last)
          state_next = `HFC_S_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      default: begin
        state_next = `HFC_S_RST;
        cnt_next   = RS_CYC;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      // Power-up always begins with a device reset pulse.
      state_reg          <= `HFC_S_RST;
      cnt_reg            <= RS_CYC;
      reset_n_in         <= 1'b0;
      w_n                <= 1'b1;
      r_n                <= 1'b1;
      first_or_rewind_in <= 1'b1;
      wr_word_in         <= {DW{1'b0}};
      wcnt_reg           <= {CW{1'b0}};
      last_rd_reg        <= 1'b0;
      dev_full           <= 1'b0;
      dev_empty          <= 1'b1;
      dev_half           <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      // Strobes stay high through reset and its recovery.
      reset_n_in <= (state_next != `HFC_S_RST);
      w_n        <= (state_next != `HFC_S_WLO);
      r_n        <= (state_next != `HFC_S_RLO);
      // Retransmit pulse with both strobes held high.
      first_or_rewind_in <= (state_next != `HFC_S_TLO);
      // Word held from falling strobe until the next write.
      if (wr_go)
        wr_word_in <= wr_data;
      if (rst_go)
        wcnt_reg <= {CW{1'b0}};
      else if (wr_go && rewind_ok)
        wcnt_reg <= wcnt_reg + {{(CW-1){1'b0}}, 1'b1};
      if (rd_go)
        last_rd_reg <= 1'b1;
      else if (wr_go)
        last_rd_reg <= 1'b0;
      dev_full  <= ~full_ind_n;
      dev_empty <= ~empty_ind_n;
      dev_half  <= ~half_full_ind_n;
    end
  end

  // ========================================================================
  // Read words pass a two-entry buffer so a stalled consumer loses none.
  hfc_skid #(
    .W (DW)
  ) u_skid (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (sk_push),
    .in_ready  (sk_in_ready),
    .in_data   (rd_word_out),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

endmodule // hfc_ctrl

// *** verification/hfc_ctrl_checker.sv ***
/* Pin protocol assertions for hfc_ctrl.
 Sees only hfc_ctrl ports; bound below. */
`timescale 1ns/1ps
module hfc_ctrl_checker #(
  parameter DW = 9
) (
  input wire          clk,
  input wire          sys_rst,
  input wire          w_n,
  input wire          r_n,
  input wire          reset_n_in,
  input wire          first_or_rewind_in,
  input wire          chain_in_n,
  input wire [DW-1:0] wr_word_in,
  input wire          dev_full,
  input wire          dev_empty,
  input wire          rewind_ok,
  input wire          rd_valid,
  input wire          rd_ready,
  input wire [DW-1:0] rd_data
);
  // ======
  // Strobe and handshake checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_wr_pulse: assert property ($fell(w_n) |=> !w_n ##1 w_n)
    else $error("write strobe width wrong");
  a_wr_full: assert property ($fell(w_n) |-> !$past(dev_full))
    else $error("write started while full");
  a_wr_data: assert property (
    !w_n && $past(!w_n) |-> $stable(wr_word_in))
    else $error("write word moved");
  a_rd_pulse: assert property ($fell(r_n) |=> !r_n ##1 r_n)
    else $error("read strobe width wrong");
  a_rd_empty: assert property ($fell(r_n) |-> !$past(dev_empty))
    else $error("read started while empty");
  a_rst_strobes: assert property (!reset_n_in |-> w_n && r_n)
    else $error("strobe low in reset");
  a_rst_recov: assert property (
    $rose(reset_n_in) |-> (w_n && r_n)[*2])
    else $error("strobe low in recovery");
  a_rst_pulse: assert property (
    $fell(reset_n_in) |=> !reset_n_in ##1 reset_n_in)
    else $error("reset pulse width wrong");
  a_rt_strobes: assert property (!first_or_rewind_in |-> w_n && r_n)
    else $error("strobe low in rewind");
  a_rt_gate: assert property (
    $fell(first_or_rewind_in) |-> $past(rewind_ok))
    else $error("rewind without room");
  a_chain_single: assert property (chain_in_n == 1'b0)
    else $error("chain input not low");
  a_rd_hold: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read word dropped");
  c_wr: cover property ($fell(w_n));
  c_rd: cover property ($fell(r_n));
  c_rt: cover property ($fell(first_or_rewind_in));
endmodule // hfc_ctrl_checker

bind hfc_ctrl hfc_ctrl_checker #(.DW(DW)) u_hfc_ctrl_checker (
  .clk(clk), .sys_rst(sys_rst), .w_n(w_n), .r_n(r_n),
  .reset_n_in(reset_n_in), .first_or_rewind_in(first_or_rewind_in),
  .chain_in_n(chain_in_n), .wr_word_in(wr_word_in), .dev_full(dev_full),
  .dev_empty(dev_empty), .rewind_ok(rewind_ok), .rd_valid(rd_valid),
  .rd_ready(rd_ready), .rd_data(rd_data));

// *** verification/hfc_dev_model.sv ***
/* Behavioural strobe-driven 9-bit FIFO device.
 Assumes strobes change on clk edges; flags follow clk. */
`timescale 1ns/1ps
module hfc_dev_model #(
  parameter DEPTH = 8
) (
  input  wire       clk,
  input  wire       reset_n_in,
  input  wire       w_n,
  input  wire       r_n,
  input  wire       first_or_rewind_in,
  input  wire       chain_in_n,
  input  wire [8:0] wr_word_in,
  output wire [8:0] rd_word_out,
  output wire       full_ind_n,
  output wire       empty_ind_n,
  output wire       half_full_ind_n
);
  // ======
  // Pointers advance at the falling strobe, so flags move early.
  logic [8:0] mem [0:DEPTH-1];
  logic [8:0] q;
  integer     wp, rp, ws;
  logic       wl, rl, wa, ra;
  always @(posedge clk) begin
    wl <= w_n;
    rl <= r_n;
    if (!reset_n_in) begin
      wp <= 0;
      rp <= 0;
      wa <= 0;
      ra <= 0;
    end else if (!first_or_rewind_in && !chain_in_n) begin
      rp <= 0;
    end else begin
      if (wl && !w_n && wp - rp != DEPTH) begin
        wa <= 1;
        ws <= wp;
        wp <= wp + 1;
      end
      if (!w_n && wa) mem[ws % DEPTH] <= wr_word_in;
      if (w_n) wa <= 0;
      if (rl && !r_n && wp != rp) begin
        q <= mem[rp % DEPTH];
        rp <= rp + 1;
        ra <= 1;
      end
      if (r_n) ra <= 0;
    end
  end
  assign rd_word_out = (!r_n && ra) ? q : ~q;
  assign full_ind_n = !(wp - rp == DEPTH);
  assign empty_ind_n = !(wp == rp);
  assign half_full_ind_n = !(wp - rp > DEPTH / 2);
endmodule // hfc_dev_model

// *** verification/hfc_ctrl_tb.sv ***
/* Self-checking bench for hfc_ctrl with a device model.
 Drives user ports at the falling clock edge. */
`timescale 1ns/1ps
module hfc_ctrl_tb;
  localparam DEPTH = 8;
  logic clk = 0, sys_rst = 1, dev_reset_req = 0, rewind_req = 0;
  logic wr_valid = 0, rd_ready = 0;
  logic [8:0] wr_data = 9'h000, rd_data, wr_word_in, rd_word_out;
  logic dev_reset_ready, wr_ready, rd_valid, rewind_ready, rewind_ok;
  logic busy, dev_full, dev_empty, dev_half, reset_n_in, w_n, r_n;
  logic first_or_rewind_in, chain_in_n, full_ind_n, empty_ind_n, hf_n;
  int n_fail = 0, checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  hfc_ctrl #(.DEPTH(DEPTH)) u_hfc_ctrl (
    .clk(clk), .sys_rst(sys_rst), .dev_reset_req(dev_reset_req),
    .dev_reset_ready(dev_reset_ready), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .rewind_req(rewind_req),
    .rewind_ready(rewind_ready), .rewind_ok(rewind_ok), .busy(busy),
    .dev_full(dev_full), .dev_empty(dev_empty), .dev_half(dev_half),
    .reset_n_in(reset_n_in), .w_n(w_n), .r_n(r_n),
    .first_or_rewind_in(first_or_rewind_in), .chain_in_n(chain_in_n),
    .wr_word_in(wr_word_in), .rd_word_out(rd_word_out),
    .full_ind_n(full_ind_n), .empty_ind_n(empty_ind_n),
    .half_full_ind_n(hf_n));
  hfc_dev_model #(.DEPTH(DEPTH)) u_hfc_dev_model (
    .clk(clk), .reset_n_in(reset_n_in), .w_n(w_n), .r_n(r_n),
    .first_or_rewind_in(first_or_rewind_in), .chain_in_n(chain_in_n),
    .wr_word_in(wr_word_in), .rd_word_out(rd_word_out),
    .full_ind_n(full_ind_n), .empty_ind_n(empty_ind_n),
    .half_full_ind_n(hf_n));
  // ======
  // Tasks.
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] d, output bit ok);
    wr_data = d;
    wr_valid = 1;
    ok = 0;
    for (int n = 0; n < 60 && !ok; n++) begin
      #1 ok = (wr_ready === 1'b1);
      @(negedge clk);
    end
    wr_valid = 0;
    // Let an edge pass so a following call never re-raises at once.
    @(negedge clk);
  endtask
  task automatic rd(output logic [8:0] d, output bit ok);
    rd_ready = 1;
    ok = 0;
    for (int n = 0; n < 60 && !ok; n++) begin
      #1 ok = (rd_valid === 1'b1);
      d = rd_data;
      @(negedge clk);
    end
    rd_ready = 0;
    @(negedge clk);
  endtask
  task automatic req(input bit rw);
    bit ok;
    rewind_req = rw;
    dev_reset_req = !rw;
    ok = 0;
    for (int n = 0; n < 60 && !ok; n++) begin
      #1 ok = rw ? rewind_ready === 1'b1 : dev_reset_ready === 1'b1;
      @(negedge clk);
    end
    rewind_req = 0;
    dev_reset_req = 0;
    chk("request taken", 9'h001, {8'h00, ok});
    repeat (10) @(negedge clk);
  endtask
  task end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // A hang anywhere ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  // ======
  // Tests.
  initial begin
    bit ok;
    logic [8:0] d;
    repeat (12) @(negedge clk);
    sys_rst = 0;
    repeat (10) @(negedge clk);
    chk("empty", 9'h001, {8'h00, dev_empty});
    chk("half", 9'h000, {8'h00, dev_half});
    chk("rewind_ok", 9'h001, {8'h00, rewind_ok});
    chk("busy", 9'h000, {8'h00, busy});
    $display("test reset done");
    for (int i = 0; i < DEPTH + 2; i++) begin
      wr(9'h1a5 ^ 9'(i), ok);
      chk("write taken", 9'h001, {8'h00, ok});
      chk("busy", 9'h001, {8'h00, busy});
    end
    repeat (20) @(negedge clk);
    chk("full", 9'h001, {8'h00, dev_full});
    chk("half", 9'h001, {8'h00, dev_half});
    chk("rewind_ok", 9'h000, {8'h00, rewind_ok});
    wr(9'h000, ok);
    chk("write refused", 9'h000, {8'h00, ok});
    chk("busy", 9'h000, {8'h00, busy});
    $display("test fill done");
    for (int i = 0; i < DEPTH + 2; i++) begin
      rd(d, ok);
      chk("read word", 9'h1a5 ^ 9'(i), d);
    end
    repeat (20) @(negedge clk);
    chk("full", 9'h000, {8'h00, dev_full});
    chk("empty", 9'h001, {8'h00, dev_empty});
    rd(d, ok);
    chk("read refused", 9'h000, {8'h00, ok});
    $display("test drain done");
    req(0);
    for (int i = 0; i < 3; i++) wr(9'h0f0 + 9'(i), ok);
    for (int i = 0; i < 3; i++) begin
      rd(d, ok);
      chk("read word", 9'h0f0 + 9'(i), d);
    end
    chk("rewind_ok", 9'h001, {8'h00, rewind_ok});
    req(1);
    for (int i = 0; i < 3; i++) begin
      rd(d, ok);
      chk("replay word", 9'h0f0 + 9'(i), d);
    end
    $display("test rewind done");
    end_sim;
  end
endmodule // hfc_ctrl_tb
